// ---- design/vls_pkg.sv ----
// shared constants and types for the line supervisor
package vls_pkg;
  // line select codes
  localparam logic [2:0] SEL_AUTO_MAX    = 3'h2;
  localparam logic [2:0] SEL_TRANSPARENT = 3'h3;
  localparam logic [2:0] SEL_TRIPLE      = 3'h7;
  // command field positions
  localparam int LINE_SEL_LSB      = 0;
  localparam int SURVEILLANCE_POS  = 3;
  localparam int OWNER_LSB         = 4;
  localparam int LOCK_POS          = 7;
  localparam logic [7:0] CMD_RESET = 8'h00;
  // local addresses of the two register frames
  localparam logic [2:0] LADDR_CMD_WRITE = 3'h0;
  localparam logic [2:0] LADDR_STA_READ  = 3'h1;
  // timing: long timeout base in ms, clock rate in kHz
  localparam int LONG_TIMEOUT_MS = 1000;
  localparam int CLK_KHZ         = 20000;
  // tick rate of the timeout base: 1 ms ticks
  localparam int TICK_CYCLES     = CLK_KHZ;
  localparam int SHORT_DIV       = 16;
  localparam int MEDIUM_DIV      = 4;
  localparam int SUPER_MUL       = 4;
  localparam int SWITCH_PERIODS  = 32;
  typedef enum logic [1:0]
  {
    ST_NORMAL = 2'b00,
    ST_SAFETY = 2'b01
  } vls_mode_t;
endpackage

// ---- design/vls_tick_div.sv ----
// divider producing a one-cycle tick enable
`timescale 1ns/1ps
module vls_tick_div #(
  parameter int DIV = 20000
) (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);
  typedef struct packed
  {
    logic [15:0] cnt;
    logic        tick;
  } vls_div_st_t;
  vls_div_st_t st;
  vls_div_st_t next_st;
  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == 16'(DIV - 1))
    begin
      next_st.cnt = 16'h0000;
      next_st.tick = 1'b1;
    end
    else
    begin
      next_st.cnt = st.cnt + 16'h0001;
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end
  assign tick_o = st.tick;
endmodule

// ---- design/vls_timer.sv ----
// restartable timeout counter on tick enables
`timescale 1ns/1ps
module vls_timer #(
  parameter int LIMIT = 1000
) (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic tick_i,
  input  wire logic restart_i,
  output logic      expired_o
);
  typedef struct packed
  {
    logic [15:0] cnt;
    logic        expired;
  } vls_tmr_st_t;
  vls_tmr_st_t st;
  vls_tmr_st_t next_st;
  always_comb
  begin
    next_st = st;
    next_st.expired = 1'b0;
    if (restart_i)
      next_st.cnt = 16'h0000;
    else if (tick_i)
    begin
      if (st.cnt == 16'(LIMIT - 1))
      begin
        next_st.cnt = 16'h0000;
        next_st.expired = 1'b1;
      end
      else
        next_st.cnt = st.cnt + 16'h0001;
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end
  assign expired_o = st.expired;
endmodule

// ---- design/vls_supervisor.sv ----
// line diagnosis and safety mode supervisor
// How it works
// - short timeout fires after dominant level lasts long base divided by 16
// - medium timeout fires after base/4 without any coherent frame
// - long timeout fires after base without an addressed coherent frame
// - super-long timeout equals four long periods on the same base
// - low command bits pick auto start line, transparent, forced, triple
// - auto mode steps lines 0,1,2 cyclically on diagnosis timeouts
// - select code 3 updates bits 7:3, keeps line and selection mode
// - forced modes keep the line whatever timeouts occur
// - status 1:0 show selected line, bit 2 shows three-line agreement
// - agreement true when all three line inputs equal
// - command bit 3 inhibits surveillance; status bit 3 shows safety mode
// - inhibited surveillance: no safety, interrupt pulse per addressed frame
// - bits 6:4 owner number, bit 7 lock; status mirrors both
// - command writes always accepted, whatever lock or mode
// - lock never blocks port writes; masters check status first
// - reset clears command: auto from line 0, surveillance on, free
// - reset: ports hi-z, int low; safety: port A hi-z, B held, int high
// - after reset, no access for super-long period enters safety
// - in operation, frames but no access for long period enters safety
// - port A write leaves safety and drops interrupt
// - 32 periods after reset the safety clock moves to the RC pin
// - address 0 frame writes command byte, address 1 reads status
// - interrupt pin signals active safety mode
`timescale 1ns/1ps
module vls_supervisor #(
  parameter int TICK_CYCLES = vls_pkg::TICK_CYCLES,
  parameter int LONG_TICKS  = vls_pkg::LONG_TIMEOUT_MS
) (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       diff_line_input_i,
  input  wire logic       true_line_input_i,
  input  wire logic       comp_line_input_i,
  input  wire logic       safety_clk_pin_i,
  input  wire logic       ring_osc_clk_i,
  input  wire logic       frame_end_i,
  input  wire logic       frame_coherent_i,
  input  wire logic       frame_for_us_i,
  input  wire logic [2:0] frame_laddr_i,
  input  wire logic [7:0] frame_data_i,
  input  wire logic       frame_one_byte_i,
  input  wire logic       port_a_write_i,
  output logic            rx_line_o,
  output logic [1:0]      line_sel_o,
  output logic [7:0]      status_o,
  output logic            int_o,
  output logic            port_a_hiz_o,
  output logic            port_b_hiz_o,
  output logic            port_b_hold_o,
  output logic            safety_clk_ext_o,
  output logic            safety_clk_o
);
  typedef struct packed
  {
    logic [7:0]        cmd;
    logic [1:0]        line;
    vls_pkg::vls_mode_t mode;
    logic              after_reset;
    logic [5:0]        sw_cnt;
    logic              clk_ext;
    logic              clk_out;
    logic              rx;
    logic              intr;
    logic              pa_hiz;
    logic              pb_hiz;
    logic              pb_hold;
    logic [7:0]        status;
  } vls_st_t;
  vls_st_t st;
  vls_st_t next_st;
  logic tick;
  logic short_exp;
  logic medium_exp;
  logic long_exp;
  logic super_exp;
  logic agree;
  logic cmd_write;
  logic access;
  logic dominant;
  logic selected_rx;
  function automatic logic pick_line(input logic [1:0] l,
                                     input logic a, input logic b,
                                     input logic c);
    case (l)
      2'h0:    pick_line = a;
      2'h1:    pick_line = b;
      2'h2:    pick_line = c;
      default: pick_line = a;
    endcase
  endfunction
  assign agree = (diff_line_input_i & true_line_input_i & comp_line_input_i)
    | (~diff_line_input_i & ~true_line_input_i & ~comp_line_input_i);
  assign cmd_write = frame_end_i & frame_coherent_i & frame_for_us_i
    & frame_one_byte_i
    & (frame_laddr_i == vls_pkg::LADDR_CMD_WRITE);
  assign access = frame_end_i & frame_coherent_i & frame_for_us_i;
  assign selected_rx = pick_line(st.line, diff_line_input_i,
                                 true_line_input_i, comp_line_input_i);
  assign dominant = ~selected_rx;
  vls_tick_div #(
    .DIV (TICK_CYCLES)
  ) u_div (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .tick_o  (tick)
  );
  vls_timer #(
    .LIMIT (LONG_TICKS / vls_pkg::SHORT_DIV)
  ) u_short (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (tick),
    .restart_i (~dominant),
    .expired_o (short_exp)
  );
  vls_timer #(
    .LIMIT (LONG_TICKS / vls_pkg::MEDIUM_DIV)
  ) u_medium (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (tick),
    .restart_i (frame_end_i & frame_coherent_i),
    .expired_o (medium_exp)
  );
  vls_timer #(
    .LIMIT (LONG_TICKS)
  ) u_long (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (tick),
    .restart_i (access),
    .expired_o (long_exp)
  );
  vls_timer #(
    .LIMIT (LONG_TICKS * vls_pkg::SUPER_MUL)
  ) u_super (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (tick),
    .restart_i (access),
    .expired_o (super_exp)
  );
  always_comb
  begin
    next_st = st;
    next_st.intr = 1'b0;
    // command write, never blocked by lock
    if (cmd_write)
    begin
      if (frame_data_i[2:0] == vls_pkg::SEL_TRANSPARENT)
        next_st.cmd[7:3] = frame_data_i[7:3];
      else
      begin
        next_st.cmd = frame_data_i;
        if (frame_data_i[2:0] == vls_pkg::SEL_TRIPLE)
          next_st.line = 2'h0;
        else
          next_st.line = frame_data_i[1:0];
      end
    end
    else if (st.cmd[2] == 1'b0
             && st.cmd[2:0] != vls_pkg::SEL_TRANSPARENT
             && (short_exp | medium_exp | long_exp))
    begin
      if (st.line == vls_pkg::SEL_AUTO_MAX[1:0])
        next_st.line = 2'h0;
      else
        next_st.line = st.line + 2'h1;
    end
    if (access)
      next_st.after_reset = 1'b0;
    // safety entry and exit
    if (st.mode == vls_pkg::ST_NORMAL)
    begin
      if (!st.cmd[vls_pkg::SURVEILLANCE_POS]
          && ((st.after_reset && super_exp)
              || (!st.after_reset && long_exp)))
      begin
        next_st.mode = vls_pkg::ST_SAFETY;
        next_st.pa_hiz = 1'b1;
        next_st.pb_hold = 1'b1;
      end
    end
    else if (port_a_write_i)
    begin
      next_st.mode = vls_pkg::ST_NORMAL;
      next_st.pa_hiz = 1'b0;
      next_st.pb_hiz = 1'b0;
      next_st.pb_hold = 1'b0;
    end
    if (port_a_write_i && st.mode == vls_pkg::ST_NORMAL)
    begin
      next_st.pa_hiz = 1'b0;
      next_st.pb_hiz = 1'b0;
    end
    // interrupt: level in safety, pulse per addressed frame when inhibited
    if (next_st.mode == vls_pkg::ST_SAFETY)
      next_st.intr = 1'b1;
    else if (st.cmd[vls_pkg::SURVEILLANCE_POS] && access)
      next_st.intr = 1'b1;
    // safety clock switch after 32 periods
    if (!st.clk_ext)
    begin
      if (st.sw_cnt == 6'(vls_pkg::SWITCH_PERIODS - 1))
        next_st.clk_ext = 1'b1;
      else
        next_st.sw_cnt = st.sw_cnt + 6'h01;
    end
    next_st.clk_out = st.clk_ext ? safety_clk_pin_i : ring_osc_clk_i;
    if (st.cmd[2:0] == vls_pkg::SEL_TRIPLE)
      next_st.rx = agree ? diff_line_input_i : st.rx;
    else
      next_st.rx = selected_rx;
    next_st.status = {next_st.cmd[7:4],
                      next_st.mode == vls_pkg::ST_SAFETY,
                      agree, next_st.line};
  end
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= '0;
      st.cmd <= vls_pkg::CMD_RESET;
      st.after_reset <= 1'b1;
      st.rx <= 1'b1;
      st.pa_hiz <= 1'b1;
      st.pb_hiz <= 1'b1;
    end
    else
      st <= next_st;
  end
  assign rx_line_o = st.rx;
  assign line_sel_o = st.line;
  assign status_o = st.status;
  assign int_o = st.intr;
  assign port_a_hiz_o = st.pa_hiz;
  assign port_b_hiz_o = st.pb_hiz;
  assign port_b_hold_o = st.pb_hold;
  assign safety_clk_ext_o = st.clk_ext;
  assign safety_clk_o = st.clk_out;
endmodule

// ---- test/vls_bus_model.sv ----
// far side model: receive lines and frame reports
`timescale 1ns/1ps
module vls_bus_model (
  input  wire logic  clock_i,
  output logic [2:0] lines_o,
  output logic       fe_o,
  output logic       coh_o,
  output logic       us_o,
  output logic [2:0] la_o,
  output logic [7:0] dat_o,
  output logic       one_o,
  output logic       pa_o
);
  initial {lines_o, fe_o, coh_o, us_o, la_o, dat_o, one_o, pa_o} = 19'h70000;
  task automatic lines(input logic [2:0] v);
    @(posedge clock_i);
    lines_o <= v;
  endtask
  // qualifiers go to junk once the report is over
  task automatic frame(input logic [2:0] a, input logic [7:0] d,
                       input logic one, input logic us);
    @(posedge clock_i);
    {fe_o, coh_o, us_o, la_o, dat_o, one_o} <= {2'b11, us, a, d, one};
    @(posedge clock_i);
    {fe_o, coh_o, us_o, la_o, dat_o, one_o} <= {2'b00, ~us, ~a, ~d, ~one};
  endtask
  // port writes go out whatever the lock
  task automatic pa();
    @(posedge clock_i);
    pa_o <= 1'b1;
    @(posedge clock_i);
    pa_o <= 1'b0;
  endtask
endmodule

// ---- test/vls_supervisor_sva.sv ----
// port assertions for the line supervisor
`timescale 1ns/1ps
module vls_supervisor_sva (
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic       diff_line_input_i,
  input wire logic       true_line_input_i,
  input wire logic       comp_line_input_i,
  input wire logic       frame_end_i,
  input wire logic       frame_coherent_i,
  input wire logic       frame_for_us_i,
  input wire logic [2:0] frame_laddr_i,
  input wire logic [7:0] frame_data_i,
  input wire logic       frame_one_byte_i,
  input wire logic       port_a_write_i,
  input wire logic [1:0] line_sel_o,
  input wire logic [7:0] status_o,
  input wire logic       int_o,
  input wire logic       safety_clk_ext_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic       wr;
  logic       agr;
  logic [5:0] cnt;
  assign wr = frame_end_i & frame_coherent_i & frame_for_us_i & frame_one_byte_i
            & (frame_laddr_i == vls_pkg::LADDR_CMD_WRITE);
  assign agr = (diff_line_input_i & true_line_input_i & comp_line_input_i)
             | ~(diff_line_input_i | true_line_input_i | comp_line_input_i);
  always_ff @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i)
      cnt <= 6'h00;
    else if (cnt != 6'h3f)
      cnt <= cnt + 6'h01;
  AST_LINE_MIRROR: assert property (status_o[1:0] == line_sel_o)
    else $error("status line field differs from line select");
  AST_AGREE: assert property ($past(rst_n_i) |-> status_o[2] == $past(agr))
    else $error("agreement bit wrong");
  AST_CMD_LINE: assert property (wr && frame_data_i[2:0] != 3'h3 |=>
    line_sel_o == (($past(frame_data_i[2:0]) == vls_pkg::SEL_TRIPLE) ?
    2'h0 : $past(frame_data_i[1:0])))
    else $error("line not taken from command");
  AST_CMD_KEEP: assert property (wr && frame_data_i[2:0] == 3'h3 |=>
    $stable(line_sel_o)) else $error("transparent write moved line");
  AST_CMD_HIGH: assert property (wr |=>
    status_o[7:4] == $past(frame_data_i[7:4])) else $error("lock/owner wrong");
  AST_REFUSED: assert property (frame_end_i && !frame_one_byte_i |=>
    $stable(status_o[7:4])) else $error("long command frame accepted");
  AST_SAFE_INT: assert property ($rose(status_o[3]) |-> ##[0:1] int_o)
    else $error("safety without interrupt");
  AST_EXIT: assert property (port_a_write_i && !frame_end_i |=>
    !status_o[3] && !int_o) else $error("port write did not leave safety");
  AST_CLK_EARLY: assert property (cnt < 6'h1e |-> !safety_clk_ext_o)
    else $error("safety clock switched early");
  AST_CLK_LATE: assert property (cnt > 6'h22 |-> safety_clk_ext_o)
    else $error("safety clock not switched");
endmodule
bind vls_supervisor vls_supervisor_sva u_sva (.clock_i(clock_i),
  .rst_n_i(rst_n_i), .diff_line_input_i(diff_line_input_i),
  .true_line_input_i(true_line_input_i),
  .comp_line_input_i(comp_line_input_i), .frame_end_i(frame_end_i),
  .frame_coherent_i(frame_coherent_i), .frame_for_us_i(frame_for_us_i),
  .frame_laddr_i(frame_laddr_i), .frame_data_i(frame_data_i),
  .frame_one_byte_i(frame_one_byte_i), .port_a_write_i(port_a_write_i),
  .line_sel_o(line_sel_o), .status_o(status_o), .int_o(int_o),
  .safety_clk_ext_o(safety_clk_ext_o));

// ---- test/vls_supervisor_tb.sv ----
// self-checking bench for the line supervisor
`timescale 1ns/1ps
module vls_supervisor_tb;
  logic       clock_i;
  logic       rst_n_i;
  logic [2:0] ln;
  logic [2:0] la;
  logic [7:0] dat;
  logic [7:0] status;
  logic [1:0] sel;
  logic       fe, coh, us, one, pa, ahz, bhz, bho, ext, int_o;
  logic       rc_pin;
  logic       sclk;
  int         err_count = 0;
  int         checked = 0;
  int         cyc = 0;
  vls_bus_model bm (.clock_i(clock_i), .lines_o(ln), .fe_o(fe), .coh_o(coh),
    .us_o(us), .la_o(la), .dat_o(dat), .one_o(one), .pa_o(pa));
  vls_supervisor #(.TICK_CYCLES(4), .LONG_TICKS(32)) dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .diff_line_input_i(ln[0]),
    .true_line_input_i(ln[1]), .comp_line_input_i(ln[2]),
    .safety_clk_pin_i(rc_pin), .ring_osc_clk_i(1'b0), .frame_end_i(fe),
    .frame_coherent_i(coh), .frame_for_us_i(us), .frame_laddr_i(la),
    .frame_data_i(dat), .frame_one_byte_i(one), .port_a_write_i(pa),
    .rx_line_o(), .line_sel_o(sel), .status_o(status), .int_o(int_o),
    .port_a_hiz_o(ahz), .port_b_hiz_o(bhz), .port_b_hold_o(bho),
    .safety_clk_ext_o(ext), .safety_clk_o(sclk));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // reset state, clock move, then idle until safety
  task automatic t_reset_idle();
    wt(0);
    chk(status, 8'h00);
    chk({ahz, bhz, bho, int_o}, 8'h0c);
    wt(2);
    chk(sclk, 8'h00);
    wt(38);
    chk({ext, sclk}, 8'h03);
    wt(440);
    chk(status[3], 8'h00);
    wt(50);
    chk({status[3], int_o, ahz, bho}, 8'h0f);
    bm.pa();
    wt(0);
    chk({status[3], int_o}, 8'h00);
  endtask
  // every line code, transparent keep, refused long frame
  task automatic t_codes();
    for (int c = 0; c < 8; c++)
      if (c != 3)
      begin
        bm.frame(3'h0, 8'(c), 1'b1, 1'b1);
        wt(0);
        chk(sel, (c == 7) ? 8'h00 : 8'(c[1:0]));
      end
    bm.frame(3'h0, 8'h95, 1'b1, 1'b1);
    wt(0);
    chk({status[7:4], status[2:0]}, 8'h4d);
    bm.frame(3'h0, 8'h03, 1'b1, 1'b1);
    wt(0);
    chk({status[7:4], sel}, 8'h01);
    bm.frame(3'h0, 8'h86, 1'b0, 1'b1);
    wt(0);
    chk(status[7:4], 8'h00);
  endtask
  // forced line holds, auto steps on dominant line
  task automatic t_lines();
    bm.lines(3'h5);
    bm.frame(3'h0, 8'h05, 1'b1, 1'b1);
    wt(20);
    chk({sel, status[2]}, 8'h02);
    bm.frame(3'h0, 8'h01, 1'b1, 1'b1);
    wt(16);
    chk(sel, 8'h02);
    bm.lines(3'h7);
  endtask
  // foreign frames only: safety after one long period
  task automatic t_live();
    bm.frame(3'h0, 8'h00, 1'b1, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      bm.frame(3'h2, 8'h00, 1'b1, 1'b0);
      wt(18);
      if (i == 4)
        chk(status[3], 8'h00);
    end
    chk(status[3], 8'h01);
    bm.pa();
  endtask
  // inhibited: one pulse per addressed frame, never safety
  task automatic t_inhibit();
    int n;
    n = 0;
    bm.frame(3'h0, 8'h08, 1'b1, 1'b1);
    bm.frame(3'h1, 8'h00, 1'b1, 1'b1);
    repeat (4)
    begin
      wt(0);
      if (int_o === 1'b1)
        n++;
    end
    chk(8'(n), 8'h01);
    wt(700);
    chk(status[3], 8'h00);
  endtask
  initial
  begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      complete_run();
    end
  end
  initial
  begin
    rst_n_i = 1'b0;
    rc_pin = 1'b1;
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_reset_idle();
    t_codes();
    t_lines();
    t_live();
    t_inhibit();
    complete_run();
  end
endmodule
